// ### verilog/lbbs_pkg.sv
// Shared constants, states and carriers of the local bus burst signalling block.
package lbbs_pkg;

	// Bus widths.
	localparam int DAT_W = 32;
	localparam int ADR_W = 30;
	localparam int BE_W  = 4;
	localparam int ID_W  = 4;

	// Total width of the pin group that passes the input synchroniser.
	localparam int SYNC_W = 4 + BE_W + ADR_W + DAT_W + ID_W;

	// Clock and the high drive before the burst-ready line is released.
	localparam int CLK_PERIOD_PS = 8000;
	localparam int PARK_HIGH_PS  = CLK_PERIOD_PS / 2;
	localparam int PARK_HIGH_CYC = (PARK_HIGH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [1:0] PARK_HIGH_CNT = 2'(PARK_HIGH_CYC);

	// Identifier pin that carries the High Speed Write option, and its enabling level.
	localparam int   HSW_ID_BIT   = 2;
	localparam logic HSW_ON_LEVEL = 1'h1;

	// Data/code status levels; the default is the data level.
	localparam logic DC_DATA_LEVEL = 1'h1;
	localparam logic DC_CODE_LEVEL = 1'h0;
	localparam logic DC_DEFAULT    = DC_DATA_LEVEL;
	localparam logic MST_DC_AWARE  = 1'h1;

	// Pin levels.
	localparam logic PIN_HIGH = 1'h1;
	localparam logic PIN_LOW  = 1'h0;
	localparam logic [BE_W-1:0]  BE_NONE  = 4'hF;
	localparam logic [DAT_W-1:0] DAT_ZERO = 32'h0;
	localparam logic [ADR_W-1:0] ADR_ZERO = 30'h0;
	localparam logic [ID_W-1:0]  ID_ZERO  = 4'h0;

	typedef enum logic [2:0] {
		TS_IDLE  = 3'h0,
		TS_FIRST = 3'h1,
		TS_WAIT  = 3'h2,
		TS_READY = 3'h3,
		TS_PARK  = 3'h4
	} lbbs_tgt_e;

	typedef enum logic [1:0] {
		MS_IDLE   = 2'h0,
		MS_SETUP  = 2'h1,
		MS_STROBE = 2'h2,
		MS_WAIT   = 2'h3
	} lbbs_mst_e;

	// Master command from the adapter's own logic.
	typedef struct packed {
		logic [ADR_W-1:0] adr;
		logic [BE_W-1:0]  beN;
		logic [DAT_W-1:0] data;
		logic             write;
		logic             code;
	} lbbs_mst_cmd_s;

	// One write beat taken as target.
	typedef struct packed {
		logic [DAT_W-1:0] data;
		logic [BE_W-1:0]  beN;
	} lbbs_wr_s;

endpackage

// ### verilog/lbbs_sync.sv
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module lbbs_sync #(
	parameter int W = 1
) (
	// Clock.
	input  wire logic         clk_sys,
	// Raw and synchronised levels.
	input  wire logic [W-1:0] dIn,
	output var  logic [W-1:0] dOut
);

	logic [W-1:0] meta_reg;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk_sys) begin
		meta_reg <= dIn;
		dOut     <= meta_reg;
	end

endmodule
`default_nettype wire

// ### verilog/lbbs_core.sv
// Local bus target and master signalling: burst ready, data bus, data/code status, identifier capture.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Burst ready is driven only during a burst this adapter has claimed, otherwise left undriven.
// - Burst ready is not driven in a clock in which the address data strobe is asserted; the code blocks it only one clock after the synchronised strobe is seen.
// - The first cycle of every burst gets at least one wait state before completion is signalled.
// - Burst ready is driven high for at least half a clock before it is released.
// - Burst ready is left undriven in the first T2 state by default.
// - With High Speed Write enabled, burst ready may already be driven in the first T2 state.
// - On reads the claiming target drives the returned data onto the data bus.
// - On writes the master drives data and the byte enables mark the valid lanes.
// - During its own master cycles the adapter drives the data/code status line.
// - A master that does not tell data from code holds data/code at its default level.
// - Identifier pins are taken as valid only while the bus reset is asserted.
// - Identifier values are captured at the release of reset and the copy is used afterwards.
// - The address data strobe is one clock long, after address and status are valid, driven by the initiator.
// - Burst ready is low for one clock per beat, and a non-burst master keeps burst last low.
// - Burst ready is synchronous, and is ignored with the burst ended when local ready is seen with it.
module lbbs_core
	import lbbs_pkg::*;
(
	// Clock and bus reset.
	input  wire logic                clk_sys,
	input  wire logic                rst_n,
	// Bus pins sampled by the adapter.
	input  wire logic                adsNIn,
	input  wire logic                blastNIn,
	input  wire logic                wrRdIn,
	input  wire logic                lrdyNIn,
	input  wire logic [BE_W-1:0]     beNIn,
	input  wire logic [ADR_W-1:0]    adrIn,
	input  wire logic [DAT_W-1:0]    datIn,
	input  wire logic [ID_W-1:0]     idIn,
	// Bus pins driven by the adapter.
	output var  logic                adsNOut,
	output var  logic                adsNOe,
	output var  logic                blastNOut,
	output var  logic                blastNOe,
	output var  logic                wrRdOut,
	output var  logic                wrRdOe,
	output var  logic [BE_W-1:0]     beNOut,
	output var  logic                beNOe,
	output var  logic [ADR_W-1:0]    adrOut,
	output var  logic                adrOe,
	output var  logic                dcNOut,
	output var  logic                dcNOe,
	output var  logic                brdyNOut,
	output var  logic                brdyNOe,
	output var  logic [DAT_W-1:0]    datOut,
	output var  logic                datOe,
	// Target side toward the adapter's logic.
	input  wire logic [ADR_W-1:0]    tgtBase,
	input  wire logic [ADR_W-1:0]    tgtMask,
	input  wire logic                tgtReady,
	input  wire logic [DAT_W-1:0]    tgtRdData,
	output var  logic                tgtActive,
	output var  logic                tgtWrite,
	output var  logic [ADR_W-1:0]    tgtAdr,
	output var  logic                tgtBeat,
	output var  lbbs_wr_s            tgtWr,
	// Master side toward the adapter's logic.
	input  wire logic                mstReq,
	input  wire logic                mstGrant,
	input  wire lbbs_mst_cmd_s       mstCmd,
	output var  logic                mstBusy,
	output var  logic                mstDone,
	output var  logic [DAT_W-1:0]    mstRdData,
	// Captured host identity.
	output var  logic [ID_W-1:0]     idCpu,
	output var  logic                hswEnabled
);

	// Synchronised pin levels.
	logic [SYNC_W-1:0] syncOut;
	logic              adsS;
	logic              blastS;
	logic              wrRdS;
	logic              lrdyS;
	logic [BE_W-1:0]   beS;
	logic [ADR_W-1:0]  adrS;
	logic [DAT_W-1:0]  datS;
	logic [ID_W-1:0]   idS;

	lbbs_sync #(
		.W (SYNC_W)
	) u_sync (
		.clk_sys (clk_sys),
		.dIn     ({adsNIn, blastNIn, wrRdIn, lrdyNIn, beNIn, adrIn, datIn, idIn}),
		.dOut    (syncOut)
	);

	assign {adsS, blastS, wrRdS, lrdyS, beS, adrS, datS, idS} = syncOut;

	lbbs_tgt_e     tgt_reg;
	lbbs_tgt_e     tgt_next;
	lbbs_mst_e     mst_reg;
	lbbs_mst_e     mst_next;
	logic [1:0]    parkCnt_reg;
	lbbs_mst_cmd_s cmd_reg;
	logic          claim;
	logic          adrHit;
	logic          lanesOk;
	logic [DAT_W-1:0] wrMasked;

	assign adrHit = ((adrS & tgtMask) == (tgtBase & tgtMask));

	// Only burst cycles are claimed; single cycles complete on local ready, outside this block.
	assign claim = (adsS == PIN_LOW) && (blastS == PIN_HIGH) && adrHit && (mst_reg == MS_IDLE);

	// Target sequence.
	always_comb begin
		tgt_next = tgt_reg;
		unique case (tgt_reg)
			TS_IDLE: begin
				if (claim) begin
					tgt_next = TS_FIRST;
				end
			end
			TS_FIRST: begin
				tgt_next = TS_WAIT;
			end
			TS_WAIT: begin
				if (lrdyS == PIN_LOW) begin
					tgt_next = TS_PARK;
				end else if (tgtReady) begin
					tgt_next = TS_READY;
				end
			end
			TS_READY: begin
				if (lrdyS == PIN_LOW) begin
					tgt_next = TS_PARK;
				end else if (blastS == PIN_LOW) begin
					tgt_next = TS_PARK;
				end else if (tgtReady) begin
					tgt_next = TS_READY;
				end else begin
					tgt_next = TS_WAIT;
				end
			end
			TS_PARK: begin
				if (parkCnt_reg == PARK_HIGH_CNT) begin
					tgt_next = TS_IDLE;
				end
			end
			default: begin
				tgt_next = TS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tgt_reg <= TS_IDLE;
		end else begin
			tgt_reg <= tgt_next;
		end
	end

	// The park count keeps the line high for the whole release interval before letting go.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			parkCnt_reg <= 2'h0;
		end else if (tgt_next == TS_PARK) begin
			parkCnt_reg <= parkCnt_reg + 2'h1;
		end else begin
			parkCnt_reg <= 2'h0;
		end
	end

	// Burst ready drive. The strobe seen at the claim edge has already left the pins, so only later strobes block it.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			brdyNOe  <= 1'h0;
			brdyNOut <= PIN_HIGH;
		end else begin
			brdyNOe <= ((adsS == PIN_HIGH) || (tgt_reg == TS_IDLE)) &&
				((tgt_next == TS_WAIT) || (tgt_next == TS_READY) || (tgt_next == TS_PARK) ||
				((tgt_next == TS_FIRST) && hswEnabled));
			brdyNOut <= (tgt_next == TS_READY) ? PIN_LOW : PIN_HIGH;
		end
	end

	// Claimed cycle context toward the adapter's logic.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tgtActive <= 1'h0;
			tgtWrite  <= 1'h0;
			tgtAdr    <= ADR_ZERO;
		end else begin
			tgtActive <= (tgt_next != TS_IDLE);
			if ((tgt_reg == TS_IDLE) && claim) begin
				tgtWrite <= wrRdS;
				tgtAdr   <= adrS;
			end
		end
	end

	// Only lanes whose byte enable is low carry data; the others are handed on as zero.
	always_comb begin
		wrMasked = DAT_ZERO;
		lanesOk  = (beS != BE_NONE);
		for (int i = 0; i < BE_W; i++) begin
			if (beS[i] == PIN_LOW) begin
				wrMasked[i*8 +: 8] = datS[i*8 +: 8];
			end
		end
	end

	// A beat counts only when burst ready was not overridden by local ready.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tgtBeat <= 1'h0;
			tgtWr   <= '0;
		end else begin
			tgtBeat <= (tgt_reg == TS_READY) && (lrdyS == PIN_HIGH);
			if ((tgt_reg == TS_READY) && tgtWrite && lanesOk) begin
				tgtWr.data <= wrMasked;
				tgtWr.beN  <= beS;
			end
		end
	end

	// Master sequence: address first, strobe one clock later, then wait for local ready.
	always_comb begin
		mst_next = mst_reg;
		unique case (mst_reg)
			MS_IDLE: begin
				if (mstReq && mstGrant && (tgt_reg == TS_IDLE) && !claim) begin
					mst_next = MS_SETUP;
				end
			end
			MS_SETUP: begin
				mst_next = MS_STROBE;
			end
			MS_STROBE: begin
				mst_next = MS_WAIT;
			end
			MS_WAIT: begin
				if (lrdyS == PIN_LOW) begin
					mst_next = MS_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mst_reg <= MS_IDLE;
			cmd_reg <= '0;
		end else begin
			mst_reg <= mst_next;
			if ((mst_reg == MS_IDLE) && (mst_next == MS_SETUP)) begin
				cmd_reg <= mstCmd;
			end
		end
	end

	// Master pin drives, all held for the whole cycle the adapter owns.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			adsNOut   <= PIN_HIGH;
			adsNOe    <= 1'h0;
			blastNOut <= PIN_LOW;
			blastNOe  <= 1'h0;
			wrRdOut   <= 1'h0;
			wrRdOe    <= 1'h0;
			beNOut    <= BE_NONE;
			beNOe     <= 1'h0;
			adrOut    <= ADR_ZERO;
			adrOe     <= 1'h0;
			dcNOut    <= DC_DEFAULT;
			dcNOe     <= 1'h0;
		end else begin
			adsNOut   <= (mst_next == MS_STROBE) ? PIN_LOW : PIN_HIGH;
			adsNOe    <= (mst_next != MS_IDLE);
			blastNOut <= PIN_LOW;
			blastNOe  <= (mst_next != MS_IDLE);
			wrRdOe    <= (mst_next != MS_IDLE);
			beNOe     <= (mst_next != MS_IDLE);
			adrOe     <= (mst_next != MS_IDLE);
			dcNOe     <= (mst_next != MS_IDLE);
			if (mst_next == MS_SETUP) begin
				wrRdOut <= mstCmd.write;
				beNOut  <= mstCmd.beN;
				adrOut  <= mstCmd.adr;
				if (MST_DC_AWARE) begin
					dcNOut <= mstCmd.code ? DC_CODE_LEVEL : DC_DATA_LEVEL;
				end else begin
					dcNOut <= DC_DEFAULT;
				end
			end
		end
	end

	// Data bus: target read data or master write data, never both at once.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			datOe  <= 1'h0;
			datOut <= DAT_ZERO;
		end else if ((tgt_next == TS_READY) && !tgtWrite) begin
			datOe  <= 1'h1;
			datOut <= tgtRdData;
		end else if ((mst_next != MS_IDLE) && ((mst_next == MS_SETUP) ? mstCmd.write : cmd_reg.write)) begin
			datOe  <= 1'h1;
			datOut <= (mst_next == MS_SETUP) ? mstCmd.data : cmd_reg.data;
		end else begin
			datOe  <= 1'h0;
			datOut <= DAT_ZERO;
		end
	end

	// Master results.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mstBusy   <= 1'h0;
			mstDone   <= 1'h0;
			mstRdData <= DAT_ZERO;
		end else begin
			mstBusy <= (mst_next != MS_IDLE);
			mstDone <= (mst_reg == MS_WAIT) && (lrdyS == PIN_LOW);
			if ((mst_reg == MS_WAIT) && (lrdyS == PIN_LOW) && !cmd_reg.write) begin
				mstRdData <= datS;
			end
		end
	end

	// The identifier copy follows the pins only while reset is held, so it freezes at release.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			idCpu      <= idS;
			hswEnabled <= (idS[HSW_ID_BIT] == HSW_ON_LEVEL);
		end
	end

endmodule
`default_nettype wire

// ### verification/lbbs_core_checker.sv
// Port assertions for the local bus signalling core.
`timescale 1ns/1ps
`default_nettype none
module lbbs_core_checker
	import lbbs_pkg::*;
(
	// Clock and reset.
	input wire logic          clk_sys,
	input wire logic          rst_n,
	// Bus pins.
	input wire logic          adsNIn,
	input wire logic          adsNOut,
	input wire logic          adsNOe,
	input wire logic          blastNOut,
	input wire logic          blastNOe,
	input wire logic          dcNOut,
	input wire logic          dcNOe,
	input wire logic          brdyNOut,
	input wire logic          brdyNOe,
	input wire logic          datOe,
	// User side.
	input wire logic          tgtActive,
	input wire logic          tgtWrite,
	input wire lbbs_mst_cmd_s mstCmd,
	input wire logic [ID_W-1:0] idCpu,
	input wire logic          hswEnabled
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	chk_brdy_claimed_only: assert property (brdyNOe |-> tgtActive) else $error("burst ready driven outside a claim");
	chk_brdy_no_ads: assert property (brdyNOe && !brdyNOut |-> adsNIn && $past(adsNIn) && $past(adsNIn, 2))
		else $error("burst ready low near a strobe");
	chk_first_wait: assert property ($rose(tgtActive) |-> brdyNOut [*2]) else $error("no wait state in first cycle");
	chk_park_high: assert property ($fell(brdyNOe) |-> $past(brdyNOut)) else $error("burst ready released low");
	chk_first_drive: assert property ($rose(tgtActive) |-> brdyNOe == hswEnabled)
		else $error("first T2 drive does not follow the option");
	chk_read_data: assert property (brdyNOe && !brdyNOut && !tgtWrite |-> datOe) else $error("read beat without data");
	chk_dc_level: assert property (adsNOe |-> dcNOe && dcNOut == (mstCmd.code ? DC_CODE_LEVEL : DC_DATA_LEVEL))
		else $error("data code status wrong");
	chk_ads_one: assert property (adsNOe && !adsNOut |=> adsNOe && adsNOut) else $error("strobe longer than one clock");
	chk_blast_low: assert property (adsNOe |-> blastNOe && !blastNOut) else $error("burst last not held low");
	chk_id_frozen: assert property (rst_n && $past(rst_n) |-> $stable(idCpu) && hswEnabled == idCpu[HSW_ID_BIT])
		else $error("identifier copy moved");
endmodule
`default_nettype wire

// ### verification/lbbs_host.sv
// Model of the host CPU and motherboard controller on the local bus.
`timescale 1ns/1ps
`default_nettype none
module lbbs_host
	import lbbs_pkg::*;
(
	// Clock and resolved lines.
	input  wire logic             clk_sys,
	input  wire logic             brdyN,
	input  wire logic             mstAds,
	input  wire logic [DAT_W-1:0] dat,
	// Host drives.
	output var  logic             hAdsN,
	output var  logic             hBlastN,
	output var  logic             hWr,
	output var  logic             lrdyN,
	output var  logic [BE_W-1:0]  hBeN,
	output var  logic [ADR_W-1:0] hAdr,
	output var  logic [DAT_W-1:0] hDat
);
	logic [DAT_W-1:0] lastRd;
	logic [DAT_W-1:0] lastWr;
	logic [DAT_W-1:0] rdWord;
	initial begin
		hAdsN = 1'h1;
		hBlastN = 1'h0;
		hWr = 1'h0;
		lrdyN = 1'h1;
		hBeN = 4'hC;
		hAdr = 30'h0;
		hDat = 32'h0;
		rdWord = 32'h2468ACE0;
	end
	// Burst of nb beats; BLAST goes low once the next beat is the last.
	task automatic burst(input logic wr, input int nb, input logic blastHi, input logic [ADR_W-1:0] a,
		input logic [DAT_W-1:0] d);
		int n;
		n = 0;
		@(posedge clk_sys) #1;
		hAdr = a;
		hWr = wr;
		hDat = d;
		hAdsN = 1'h0;
		hBlastN = blastHi;
		@(posedge clk_sys) #1;
		hAdsN = 1'h1;
		if (nb == 1) hBlastN = 1'h0;
		while (n < nb) begin
			@(posedge clk_sys) #1;
			if (!brdyN) begin
				n++;
				lastRd = dat;
				if (n == nb - 1) hBlastN = 1'h0;
			end
		end
		// Released lines show a changed pattern, not the last value.
		hDat = ~d;
		hBlastN = 1'h0;
	endtask
	// One local ready pulse, sampled at the next edge, as if another device ended the cycle.
	task automatic lrdy_pulse();
		lrdyN = 1'h0;
		@(posedge clk_sys) #1;
		lrdyN = 1'h1;
	endtask
	// Answers the adapter's own cycles with local ready after a few clocks.
	always @(posedge clk_sys) begin
		if (mstAds) begin
			repeat (3) @(posedge clk_sys);
			#1;
			lrdyN = 1'h0;
			hDat = rdWord;
			@(posedge clk_sys);
			lastWr = dat;
			#1;
			lrdyN = 1'h1;
			hDat = ~rdWord;
		end
	end
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the local bus signalling core.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import lbbs_pkg::*;
	logic clk_sys, rst_n, adsNIn, blastNIn, wrRdIn, lrdyNIn, tgtReady, mstReq, mstGrant;
	logic adsNOut, adsNOe, blastNOut, blastNOe, wrRdOut, wrRdOe, beNOe, adrOe, dcNOut, dcNOe;
	logic brdyNOut, brdyNOe, datOe, tgtActive, tgtWrite, tgtBeat, mstBusy, mstDone, hswEnabled;
	logic hAdsN, hBlastN, hWr, brdyN;
	logic [BE_W-1:0] beNIn, beNOut, hBeN;
	logic [ADR_W-1:0] adrIn, adrOut, tgtBase, tgtMask, tgtAdr, hAdr;
	logic [DAT_W-1:0] datIn, datOut, tgtRdData, mstRdData, hDat;
	logic [ID_W-1:0] idIn, idCpu;
	lbbs_wr_s tgtWr;
	lbbs_mst_cmd_s mstCmd;
	int err_total, n_compared, cyc;

	lbbs_core u_lbbs_core (.*);
	lbbs_host u_host (.clk_sys(clk_sys), .brdyN(brdyN), .mstAds(adsNOe && !adsNOut), .dat(datIn),
		.hAdsN(hAdsN), .hBlastN(hBlastN), .hWr(hWr), .lrdyN(lrdyNIn), .hBeN(hBeN), .hAdr(hAdr), .hDat(hDat));
	assign brdyN = brdyNOe ? brdyNOut : 1'h1;
	assign adsNIn = adsNOe ? adsNOut : hAdsN;
	assign blastNIn = blastNOe ? blastNOut : hBlastN;
	assign wrRdIn = wrRdOe ? wrRdOut : hWr;
	assign beNIn = beNOe ? beNOut : hBeN;
	assign adrIn = adrOe ? adrOut : hAdr;
	assign datIn = datOe ? datOut : hDat;

	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
	end

	task automatic tick();
		@(posedge clk_sys) #1;
	endtask
	task automatic check(input string nm, input logic [DAT_W-1:0] e, input logic [DAT_W-1:0] g);
		n_compared++;
		if (g !== e) begin
			$display("[ERR] %s exp %h got %h", nm, e, g);
			err_total++;
		end
	endtask
	// Waits a bounded time for a level; a missing level counts as a mismatch.
	task automatic await(ref logic s, input logic v, input string nm);
		for (int k = 0; k < 60 && s !== v; k++) tick();
		check(nm, 32'(v), 32'(s));
	endtask
	task automatic do_reset(input logic [ID_W-1:0] id);
		rst_n = 1'h0;
		idIn = id;
		repeat (10) tick();
		rst_n = 1'h1;
		idIn = ~id;
		repeat (3) tick();
		check("idCpu", 32'(id), 32'(idCpu));
		check("hswEnabled", 32'(id[HSW_ID_BIT]), 32'(hswEnabled));
	endtask
	// Target burst with one ready pulse per beat, spaced so BLAST arrives in time.
	task automatic t_burst(input logic wr, input int nb);
		fork
			u_host.burst(wr, nb, 1'h1, 30'h1234, 32'h89ABCDEF);
			begin
				await(tgtActive, 1'h1, "tgtActive");
				tick();
				repeat (nb) begin
					tgtReady = 1'h1;
					tick();
					tgtReady = 1'h0;
					await(tgtBeat, 1'h1, "tgtBeat");
					repeat (4) tick();
				end
			end
		join
		await(tgtActive, 1'h0, "tgtActive");
		check("brdyNOe", 32'h0, 32'(brdyNOe));
		check("tgtAdr", 32'h1234, 32'(tgtAdr));
		check("tgtWrite", 32'(wr), 32'(tgtWrite));
		if (wr) begin
			check("tgtWr.data", 32'h0000CDEF, tgtWr.data);
			check("tgtWr.beN", 32'hC, 32'(tgtWr.beN));
		end else
			check("readData", tgtRdData, u_host.lastRd);
	endtask
	// Local ready together with burst ready drops the beat and ends the burst drive.
	task automatic t_abort();
		int beats;
		beats = 0;
		fork
			u_host.burst(1'h0, 1, 1'h1, 30'h1234, 32'h0);
			begin
				await(tgtActive, 1'h1, "tgtActive");
				u_host.lrdy_pulse();
				tgtReady = 1'h1;
				tick();
				tgtReady = 1'h0;
				repeat (6) begin
					beats += int'(tgtBeat === 1'h1);
					tick();
				end
			end
		join
		check("abortBeats", 32'h0, 32'(beats));
		await(tgtActive, 1'h0, "tgtActive");
		check("brdyNOe", 32'h0, 32'(brdyNOe));
	endtask
	// Non-burst strobe and an address outside the window are both left alone.
	task automatic t_refuse();
		u_host.burst(1'h0, 0, 1'h0, 30'h1234, 32'h0);
		u_host.burst(1'h0, 0, 1'h1, 30'h2234, 32'h0);
		repeat (6) begin
			tick();
			check("brdyNOe", 32'h0, 32'(brdyNOe | tgtActive));
		end
	endtask
	task automatic t_master(input logic wr, input logic code);
		mstCmd = '{adr: 30'h0ABC, beN: 4'h0, data: 32'h13579BDF, write: wr, code: code};
		mstReq = 1'h1;
		tick();
		mstReq = 1'h0;
		await(mstBusy, 1'h1, "mstBusy");
		check("dcNOut", 32'(code ? DC_CODE_LEVEL : DC_DATA_LEVEL), 32'(dcNOut));
		check("adrOut", 32'h0ABC, 32'(adrOut));
		check("beNOut", 32'h0, 32'(beNOut));
		check("wrRdOut", 32'(wr), 32'(wrRdOut));
		await(mstDone, 1'h1, "mstDone");
		if (wr)
			check("mstWrite", 32'h13579BDF, u_host.lastWr);
		else
			check("mstRdData", u_host.rdWord, mstRdData);
		tick();
	endtask

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		clk_sys = 1'h0;
		rst_n = 1'h0;
		tgtReady = 1'h0;
		mstReq = 1'h0;
		mstGrant = 1'h1;
		tgtBase = 30'h1200;
		tgtMask = 30'h3FFFFF00;
		tgtRdData = 32'h5A0F3CE1;
		mstCmd = '0;
		idIn = 4'h0;
		err_total = 0;
		n_compared = 0;
		cyc = 0;
		do_reset(4'h4);
		t_burst(1'h0, 2);
		t_burst(1'h1, 1);
		t_refuse();
		t_abort();
		t_master(1'h0, 1'h1);
		t_master(1'h1, 1'h0);
		do_reset(4'hB);
		t_burst(1'h0, 1);
		t_burst(1'h1, 2);
		close_out();
	end
endmodule
bind lbbs_core lbbs_core_checker u_lbbs_core_checker (.*);
`default_nettype wire
